// >>> hw/pirf_pkg.sv
package pirf_pkg;

  // Flag vector width and register byte offsets
  localparam int unsigned PIRF_NFLAGS = 8;
  localparam int unsigned PIRF_AW = 8;
  localparam logic [7:0] PIRF_OFS_FLAGS = 8'h00;
  localparam logic [7:0] PIRF_OFS_CLEAR = 8'h04;
  localparam logic [7:0] PIRF_OFS_ENABLE = 8'h08;
  localparam logic [7:0] PIRF_OFS_CTRL = 8'h0C;
  localparam logic [7:0] PIRF_OFS_ACTIVE = 8'h10;
  localparam logic [7:0] PIRF_OFS_OVERRUN = 8'h14;

  // Flag positions inside the flag register
  localparam int unsigned PIRF_BIT_T1_ROLLOVER = 0;
  localparam int unsigned PIRF_BIT_T2_MATCH = 1;
  localparam int unsigned PIRF_BIT_CAPCMP_A = 2;
  localparam int unsigned PIRF_BIT_CAPCMP_B = 3;
  localparam int unsigned PIRF_BIT_SERIAL_PORT = 4;
  localparam int unsigned PIRF_BIT_SERIAL_COLL = 5;
  localparam int unsigned PIRF_BIT_CONV_DONE = 6;
  localparam int unsigned PIRF_BIT_T1_GATE = 7;

  // Control register fields
  localparam int unsigned PIRF_CTRL_PERIPH = 0;
  localparam int unsigned PIRF_CTRL_GLOBAL = 1;

  // Reset values
  localparam logic [7:0] PIRF_RST_FLAGS = 8'h00;
  localparam logic [7:0] PIRF_RST_ENABLE = 8'h00;
  localparam logic [7:0] PIRF_RST_OVERRUN = 8'h00;
  localparam logic [1:0] PIRF_RST_CTRL = 2'h0;
  localparam logic [31:0] PIRF_RST_RDATA = 32'h0000_0000;

  typedef logic [PIRF_NFLAGS-1:0] pirf_flags_t;

  typedef enum logic {
    PIRF_BUS_IDLE,
    PIRF_BUS_ACK
  } pirf_bus_state_t;

endpackage

// >>> hw/pirf_reg_if.sv
`timescale 1ns/10ps
`default_nettype none
interface pirf_reg_if;
  import pirf_pkg::*;
  logic wr;
  logic [PIRF_AW-1:0] addr;
  logic [7:0] wdata;
  logic [31:0] rdata;

  modport bus (
    output wr,
    output addr,
    output wdata,
    input rdata
  );
  modport regs (
    input wr,
    input addr,
    input wdata,
    output rdata
  );
endinterface
`default_nettype wire

// >>> hw/pirf_wb_slave.sv
`timescale 1ns/10ps
`default_nettype none
module pirf_wb_slave (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Wishbone classic slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [pirf_pkg::PIRF_AW-1:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Register side
  pirf_reg_if.bus rif
);
  import pirf_pkg::*;

  pirf_bus_state_t state_q, state_d;
  logic [31:0] dat_q, dat_d;
  logic req;

  assign req = i_wb_cyc & i_wb_stb;

  // Read data is sampled on taking the request and held through ack
  always_comb begin
    state_d = state_q;
    dat_d = dat_q;
    case (state_q)
      PIRF_BUS_IDLE: begin
        if (req) begin
          state_d = PIRF_BUS_ACK;
          dat_d = i_wb_we ? PIRF_RST_RDATA : rif.rdata;
        end
      end
      default: begin
        state_d = PIRF_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state_q <= PIRF_BUS_IDLE;
      dat_q <= PIRF_RST_RDATA;
    end else begin
      state_q <= state_d;
      dat_q <= dat_d;
    end
  end

  // Writes commit on the edge where the master sees ack; only lane 0 is wired
  assign rif.wr = (state_q == PIRF_BUS_ACK) & req & i_wb_we & i_wb_sel[0];
  assign rif.addr = i_wb_adr;
  assign rif.wdata = i_wb_dat[7:0];
  assign o_wb_ack = (state_q == PIRF_BUS_ACK);
  assign o_wb_dat = dat_q;
endmodule
`default_nettype wire

// >>> hw/pirf_flag_bank.sv
`timescale 1ns/10ps
`default_nettype none
module pirf_flag_bank #(
  parameter int unsigned N = 8
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Hardware set pulses and software access
  input wire logic [N-1:0] i_set,
  input wire logic i_load,
  input wire logic [N-1:0] i_load_val,
  input wire logic [N-1:0] i_clr,
  // State
  output logic [N-1:0] o_flags,
  output logic [N-1:0] o_lost
);
  logic [N-1:0] flag_q, flag_d;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_flag
      // Set pulse beats a same-cycle load or clear
      always_comb begin
        if (i_set[g]) begin
          flag_d[g] = 1'b1;
        end else if (i_load) begin
          flag_d[g] = i_load_val[g];
        end else if (i_clr[g]) begin
          flag_d[g] = 1'b0;
        end else begin
          flag_d[g] = flag_q[g];
        end
      end

      always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
          flag_q[g] <= 1'b0;
        end else begin
          flag_q[g] <= flag_d[g];
        end
      end

      // Event landed on a flag that was already pending
      assign o_lost[g] = i_set[g] & flag_q[g];
    end
  endgenerate

  assign o_flags = flag_q;
endmodule
`default_nettype wire

// >>> hw/pirf_top.sv
// Implementation choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
module pirf_top (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Wishbone classic slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [pirf_pkg::PIRF_AW-1:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Peripheral event pulses, same clock
  input wire logic i_t1_gate_evt,
  input wire logic i_conv_done_evt,
  input wire logic i_serial_collision_evt,
  input wire logic i_serial_port_evt,
  input wire logic i_capcmp_b_evt,
  input wire logic i_capcmp_a_evt,
  input wire logic i_t2_match_evt,
  input wire logic i_t1_rollover_evt,
  // Core side
  output logic [pirf_pkg::PIRF_NFLAGS-1:0] o_peripheral_irq_flags_1,
  output logic o_periph_req,
  output logic o_irq
);
  import pirf_pkg::*;

  function automatic logic hit(input logic [PIRF_AW-1:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  pirf_reg_if rif ();

  pirf_flags_t evt_set;
  pirf_flags_t flags;
  pirf_flags_t lost;
  pirf_flags_t clr_mask;
  pirf_flags_t active;
  pirf_flags_t enable_q, enable_d;
  pirf_flags_t overrun_q, overrun_d;
  logic [1:0] ctrl_q, ctrl_d;
  logic load_flags;

  // Gather event pulses into flag positions; no enable gates them
  always_comb begin
    evt_set = '0;
    evt_set[PIRF_BIT_T1_GATE] = i_t1_gate_evt;
    evt_set[PIRF_BIT_CONV_DONE] = i_conv_done_evt;
    evt_set[PIRF_BIT_SERIAL_COLL] = i_serial_collision_evt;
    evt_set[PIRF_BIT_SERIAL_PORT] = i_serial_port_evt;
    evt_set[PIRF_BIT_CAPCMP_B] = i_capcmp_b_evt;
    evt_set[PIRF_BIT_CAPCMP_A] = i_capcmp_a_evt;
    evt_set[PIRF_BIT_T2_MATCH] = i_t2_match_evt;
    evt_set[PIRF_BIT_T1_ROLLOVER] = i_t1_rollover_evt;
  end

  pirf_wb_slave u_slave (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_wb_cyc(i_wb_cyc),
    .i_wb_stb(i_wb_stb),
    .i_wb_we(i_wb_we),
    .i_wb_adr(i_wb_adr),
    .i_wb_sel(i_wb_sel),
    .i_wb_dat(i_wb_dat),
    .o_wb_dat(o_wb_dat),
    .o_wb_ack(o_wb_ack),
    .rif(rif.bus)
  );

  // Direct write loads the flags; the clear alias is write-one-to-clear
  assign load_flags = rif.wr & hit(rif.addr, PIRF_OFS_FLAGS);
  assign clr_mask = (rif.wr & hit(rif.addr, PIRF_OFS_CLEAR)) ? rif.wdata : '0;

  // Flags set by hardware clear only through software access or reset
  pirf_flag_bank #(
    .N(PIRF_NFLAGS)
  ) u_flags (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_set(evt_set),
    .i_load(load_flags),
    .i_load_val(rif.wdata),
    .i_clr(clr_mask),
    .o_flags(flags),
    .o_lost(lost)
  );

  always_comb begin
    enable_d = enable_q;
    ctrl_d = ctrl_q;
    overrun_d = overrun_q;
    if (rif.wr & hit(rif.addr, PIRF_OFS_ENABLE)) begin
      enable_d = rif.wdata;
    end else if (rif.wr & hit(rif.addr, PIRF_OFS_CTRL)) begin
      ctrl_d = rif.wdata[1:0];
    end else if (rif.wr & hit(rif.addr, PIRF_OFS_OVERRUN)) begin
      overrun_d = overrun_q & ~rif.wdata;
    end
    overrun_d = overrun_d | lost;
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      enable_q <= PIRF_RST_ENABLE;
      ctrl_q <= PIRF_RST_CTRL;
      overrun_q <= PIRF_RST_OVERRUN;
    end else begin
      enable_q <= enable_d;
      ctrl_q <= ctrl_d;
      overrun_q <= overrun_d;
    end
  end

  assign active = flags & enable_q;

  // Read-back multiplexer; unmapped addresses read as zero
  always_comb begin
    if (hit(rif.addr, PIRF_OFS_FLAGS)) begin
      rif.rdata = {24'h00_0000, flags};
    end else if (hit(rif.addr, PIRF_OFS_ENABLE)) begin
      rif.rdata = {24'h00_0000, enable_q};
    end else if (hit(rif.addr, PIRF_OFS_CTRL)) begin
      rif.rdata = {30'h0000_0000, ctrl_q};
    end else if (hit(rif.addr, PIRF_OFS_ACTIVE)) begin
      rif.rdata = {24'h00_0000, active};
    end else if (hit(rif.addr, PIRF_OFS_OVERRUN)) begin
      rif.rdata = {24'h00_0000, overrun_q};
    end else begin
      rif.rdata = PIRF_RST_RDATA;
    end
  end

  assign o_peripheral_irq_flags_1 = flags;
  assign o_periph_req = ctrl_q[PIRF_CTRL_PERIPH] & (|active);
  assign o_irq = ctrl_q[PIRF_CTRL_GLOBAL] & o_periph_req;
endmodule
`default_nettype wire

// >>> verif/pirf_evt_model.sv
`timescale 1ns/10ps
`default_nettype none
module pirf_evt_model (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Requests and event pulses
  input wire logic [7:0] i_fire,
  output logic [7:0] o_evt
);
  // One clean single-cycle pulse per request, launched after the edge
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_evt <= 8'h00;
    end else begin
      o_evt <= i_fire;
    end
  end
endmodule
`default_nettype wire

// >>> verif/pirf_top_properties.sv
`timescale 1ns/10ps
`default_nettype none
module pirf_top_properties (
  // Clock, reset and bus
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_we,
  // Events
  input wire logic i_t1_gate_evt,
  input wire logic i_conv_done_evt,
  input wire logic i_serial_collision_evt,
  input wire logic i_serial_port_evt,
  input wire logic i_capcmp_b_evt,
  input wire logic i_capcmp_a_evt,
  input wire logic i_t2_match_evt,
  input wire logic i_t1_rollover_evt,
  // Core side
  input wire logic [pirf_pkg::PIRF_NFLAGS-1:0] o_peripheral_irq_flags_1,
  input wire logic o_periph_req,
  input wire logic o_irq
);
  import pirf_pkg::*;
  pirf_flags_t fl;
  logic wr;
  assign fl = o_peripheral_irq_flags_1;
  assign wr = i_wb_cyc && i_wb_we;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  property p_gate; i_t1_gate_evt |=> fl[7]; endproperty
  a_gate: assert property (p_gate) else $error("bit 7 missed");
  property p_conv; i_conv_done_evt |=> fl[6]; endproperty
  a_conv: assert property (p_conv) else $error("bit 6 missed");
  property p_coll; i_serial_collision_evt |=> fl[5]; endproperty
  a_coll: assert property (p_coll) else $error("bit 5 missed");
  property p_ser; i_serial_port_evt |=> fl[4]; endproperty
  a_ser: assert property (p_ser) else $error("bit 4 missed");
  property p_ccb; i_capcmp_b_evt |=> fl[3]; endproperty
  a_ccb: assert property (p_ccb) else $error("bit 3 missed");
  property p_cca; i_capcmp_a_evt |=> fl[2]; endproperty
  a_cca: assert property (p_cca) else $error("bit 2 missed");
  property p_t2; (fl[1] && !wr) || i_t2_match_evt |=> fl[1]; endproperty
  a_t2: assert property (p_t2) else $error("bit 1 lost");
  property p_t1; (fl[0] && !wr) || i_t1_rollover_evt |=> fl[0]; endproperty
  a_t1: assert property (p_t1) else $error("bit 0 lost");
  property p_irq; o_irq |-> o_periph_req && (|fl); endproperty
  a_irq: assert property (p_irq) else $error("irq without cause");
  property p_rst; $fell(i_rst) |-> fl == 8'h00 && !o_irq; endproperty
  a_rst: assert property (p_rst) else $error("flags not cleared");
endmodule
bind pirf_top pirf_top_properties chk_u (.*);
`default_nettype wire

// >>> verif/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define chk(a, b) begin \
  samples_checked++; \
  if ((a) !== (b)) begin \
    fail_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); \
  end \
end
module tb_top;
  import pirf_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, preq, irq;
  logic [3:0] sel = 4'h1, sel_use = 4'h1;
  logic [7:0] adr = 8'h00, fire = 8'h00, evt, flags;
  logic [31:0] dat = 32'h0000_0000, rd, q;
  logic [7:0] exp_f = 8'h00, en = 8'h00, ctl = 8'h00, ovr = 8'h00, lfsr = 8'h2c;
  int fail_count = 0;
  int samples_checked = 0;
  always #20 i_clk_sys = ~i_clk_sys;
  pirf_evt_model ev_u (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_fire(fire), .o_evt(evt));
  pirf_top dut_u (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(dat), .o_wb_dat(rd),
    .o_wb_ack(ack), .i_t1_gate_evt(evt[7]), .i_conv_done_evt(evt[6]),
    .i_serial_collision_evt(evt[5]), .i_serial_port_evt(evt[4]), .i_capcmp_b_evt(evt[3]),
    .i_capcmp_a_evt(evt[2]), .i_t2_match_evt(evt[1]), .i_t1_rollover_evt(evt[0]),
    .o_peripheral_irq_flags_1(flags), .o_periph_req(preq), .o_irq(irq));
  function automatic logic [7:0] nxt(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [31:0] rexp(input logic [7:0] a);
    case (a)
      PIRF_OFS_FLAGS: return {24'h00_0000, exp_f};
      PIRF_OFS_ENABLE: return {24'h00_0000, en};
      PIRF_OFS_CTRL: return {24'h00_0000, ctl};
      PIRF_OFS_ACTIVE: return {24'h00_0000, exp_f & en};
      PIRF_OFS_OVERRUN: return {24'h00_0000, ovr};
      default: return 32'h0000_0000;
    endcase
  endfunction
  // One bus cycle; v fires events that land on the commit edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
    input logic [7:0] v);
    int n;
    logic wok;
    logic [7:0] lst;
    n = 0;
    wok = w && sel_use[0];
    @(posedge i_clk_sys);
    `chk(flags, exp_f)
    `chk(preq, ctl[0] & |(exp_f & en))
    `chk(irq, ctl[1] & ctl[0] & |(exp_f & en))
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= sel_use;
    adr <= a;
    dat <= {24'h00_0000, d};
    fire <= v;
    @(posedge i_clk_sys);
    n = 1;
    fire <= 8'h00;
    while (ack !== 1'b1 && n < 20) begin
      @(posedge i_clk_sys);
      n++;
    end
    q = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) begin
      fail_count++;
      end_sim();
    end
    // Events hitting an already pending flag count as overrun
    lst = v & exp_f;
    if (wok && a == PIRF_OFS_FLAGS) exp_f = d;
    if (wok && a == PIRF_OFS_CLEAR) exp_f = exp_f & ~d;
    if (wok && a == PIRF_OFS_ENABLE) en = d;
    if (wok && a == PIRF_OFS_CTRL) ctl = d & 8'h03;
    if (wok && a == PIRF_OFS_OVERRUN) ovr = ovr & ~d;
    ovr = ovr | lst;
    exp_f = exp_f | v;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] v);
    logic [31:0] e;
    e = rexp(a);
    wb(1'b0, a, 8'h00, v);
    `chk(q, e)
  endtask
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge i_clk_sys);
    fail_count++;
    end_sim();
  end
  initial begin
    repeat (12) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    rchk(PIRF_OFS_CTRL, 8'h00);
    rchk(PIRF_OFS_ENABLE, 8'h00);
    for (int b = 0; b < 8; b++) begin
      rchk(PIRF_OFS_FLAGS, 8'h01 << b);
      rchk(PIRF_OFS_FLAGS, 8'h00);
      wb(1'b1, PIRF_OFS_CLEAR, 8'h01 << b, 8'h00);
    end
    // A write without byte lane 0 must leave the register alone
    sel_use = 4'he;
    wb(1'b1, PIRF_OFS_ENABLE, 8'hff, 8'h00);
    sel_use = 4'h1;
    rchk(PIRF_OFS_ENABLE, 8'h00);
    wb(1'b1, 8'h20, 8'hff, 8'h00);
    rchk(8'h20, 8'h00);
    rchk(PIRF_OFS_CLEAR, 8'h00);
    wb(1'b1, PIRF_OFS_CLEAR, 8'hff, 8'h00);
    wb(1'b1, PIRF_OFS_ENABLE, 8'h04, 8'h00);
    wb(1'b1, PIRF_OFS_CTRL, 8'h03, 8'h04);
    wb(1'b1, PIRF_OFS_CTRL, 8'h01, 8'h00);
    repeat (60) begin
      lfsr = nxt(lfsr);
      wb(1'b1, PIRF_OFS_ENABLE, lfsr, 8'h00);
      lfsr = nxt(lfsr);
      wb(1'b1, PIRF_OFS_CTRL, {6'h00, lfsr[1:0]}, lfsr & 8'h5a);
      lfsr = nxt(lfsr);
      wb(1'b1, lfsr[0] ? PIRF_OFS_FLAGS : PIRF_OFS_CLEAR, lfsr, nxt(lfsr));
      rchk(PIRF_OFS_ACTIVE, 8'h00);
      rchk(PIRF_OFS_OVERRUN, lfsr & 8'h24);
      wb(1'b1, PIRF_OFS_OVERRUN, lfsr, 8'h00);
    end
    // Second reset in mid-run clears every register again
    @(posedge i_clk_sys);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    exp_f = 8'h00;
    en = 8'h00;
    ctl = 8'h00;
    ovr = 8'h00;
    rchk(PIRF_OFS_OVERRUN, 8'h00);
    rchk(PIRF_OFS_FLAGS, 8'h00);
    end_sim();
  end
endmodule
`default_nettype wire
